/* File: hdl/osc_top.sv */
// Purpose : tile OTP controller with security word and boot copy
// Assumes : register port and debug/link requests are on i_clock
// Notes   : security_config is captured once per reset; later
//           programming of the security cell shows after next reset
`include "osc_regs.svh"
module osc_top
	import osc_pkg::*;
#(
	parameter int unsigned PROG_CYCLES = `OSC_PROG_CYCLES // pulse length
)(
	input  wire logic                   i_clock,       // 250 MHz tile clock
	input  wire logic                   i_srst,        // sync reset, high
	input  wire logic                   i_clk_en,      // freeze when low
	input  wire logic                   i_blank,       // factory-blank OTP
	input  wire logic [`OSC_ADDR_W-1:0] i_addr,        // register address
	input  wire logic [31:0]            i_wdata,       // write data
	input  wire logic                   i_wr,          // write strobe
	input  wire logic                   i_rd,          // read strobe
	output logic      [31:0]            o_rdata,       // read data, next cycle
	input  wire osc_dbg_req_t           i_dbg_req,     // debug port request
	output osc_dbg_rsp_t                o_dbg_rsp,     // debug port answer
	output logic      [31:0]            o_usercode,    // debug usercode value
	input  wire logic                   i_link_req,    // tile access via switch
	output logic                        o_link_grant,  // access permitted
	output logic                        o_dbg_tile_en, // debug may reach tile
	output osc_sram_wr_t                o_sram_wr,     // boot copy writes
	output logic                        o_boot_go,     // processor may run
	output logic                        o_boot_otp,    // boot from OTP zero
	output logic                        o_redund_en    // redundant rows on
);
	// =============================================================
	// state
	osc_ld_state_t             ld_q;
	logic [`OSC_WADDR_W-1:0]   copy_idx_q;
	logic [31:0]               sec_cell_q;    // programmable security cell
	logic [31:0]               sec_cfg_q;     // security_config shadow
	logic [15:0]               aport_q;
	logic [31:0]               dport_q;
	logic [31:0]               rdata_q;
	logic [31:0]               otp_rd_q;      // last bus OTP word read
	logic                      done_q;
	logic                      lockerr_q;
	logic                      rd_pend_q;     // bus OTP read in flight
	logic                      prog_sec_q;    // target of pulse
	logic                      prog_dbg_q;    // pulse from debug port
	logic [15:0]               dbg_addr_q;
	logic [31:0]               dbg_data_q;
	logic                      dbg_rsp_q;
	logic                      dbg_ref_q;
	logic                      dbg_rd_q;      // served OTP read
	osc_sram_wr_t              sram_q;

	logic [31:0]               arr_rdata;
	logic                      seq_busy;
	logic                      seq_fire;
	logic                      seq_start;
	logic                      booted;
	logic                      cmd_wr;
	logic                      cmd_prog;
	logic                      cmd_read;
	logic                      cmd_ok;
	logic                      dbg_otp;
	logic                      dbg_denied;
	logic                      dbg_prog;
	logic                      dbg_read;
	logic                      dbg_ok;
	logic                      arr_rd_en;
	logic [`OSC_WADDR_W-1:0]   arr_rd_addr;
	logic                      arr_wr_en;
	logic [`OSC_WADDR_W-1:0]   arr_wr_addr;
	logic [31:0]               arr_wr_data;

	// =============================================================
	// lock decode, shared by the processor and debug paths
	function automatic logic prog_allowed(input logic [31:0] sec,
	                                      input logic [15:0] addr,
	                                      input logic        to_sec);
		logic [1:0] sector;
		sector = addr[`OSC_SECTOR_LSB+1:`OSC_SECTOR_LSB];
		if (sec[`OSC_SEC_MLOCK])
			prog_allowed = 1'b0;
		else if (to_sec)
			prog_allowed = 1'b1;
		else
			prog_allowed = !sec[`OSC_SEC_LOCK0 + sector];
	endfunction

	// =============================================================
	// storage and pulse timing
	osc_otp_array u_array (
		.i_clock   (i_clock),
		.i_clk_en  (i_clk_en),
		.i_blank   (i_blank),
		.i_wr_en   (arr_wr_en),
		.i_wr_addr (arr_wr_addr),
		.i_wr_data (arr_wr_data),
		.i_rd_en   (arr_rd_en),
		.i_rd_addr (arr_rd_addr),
		.o_rd_data (arr_rdata)
	);

	osc_prog_seq #(
		.PROG_CYCLES (PROG_CYCLES)
	) u_seq (
		.i_clock  (i_clock),
		.i_clk_en (i_clk_en),
		.i_srst   (i_srst),
		.i_start  (seq_start),
		.o_busy   (seq_busy),
		.o_fire   (seq_fire)
	);

	// =============================================================
	// power-up loader: security word, then copy every word to SRAM
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			ld_q       <= OSC_LD_FETCH;
			copy_idx_q <= '0;
			sec_cfg_q  <= `OSC_SEC_RESET;
		end else if (i_clk_en) begin
			case (ld_q)
				OSC_LD_FETCH: begin
					sec_cfg_q <= sec_cell_q;
					ld_q      <= OSC_LD_READ;
				end
				OSC_LD_READ: begin
					ld_q <= OSC_LD_WRITE;
				end
				OSC_LD_WRITE: begin
					copy_idx_q <= copy_idx_q + 1'b1;
					if (copy_idx_q == `OSC_WADDR_W'(`OSC_WORDS - 1))
						ld_q <= OSC_LD_DONE;
					else
						ld_q <= OSC_LD_READ;
				end
				OSC_LD_DONE: begin
					ld_q <= OSC_LD_DONE;
				end
				default: begin
					ld_q <= OSC_LD_FETCH;
				end
			endcase
		end
	end

	assign booted = (ld_q == OSC_LD_DONE) && !sram_q.valid; // last word out first

	// copy stream; the array answers one cycle after the read
	always_ff @(posedge i_clock) begin
		if (i_srst)
			sram_q <= '0;
		else if (i_clk_en) begin
			sram_q.valid <= (ld_q == OSC_LD_WRITE);
			sram_q.addr  <= copy_idx_q;
			sram_q.data  <= arr_rdata;
		end
	end

	// =============================================================
	// register port decode
	assign cmd_wr   = i_wr && booted && (i_addr == `OSC_ADDR_CPORT);
	assign cmd_prog = cmd_wr && i_wdata[`OSC_CTL_PROG];
	assign cmd_read = cmd_wr && i_wdata[`OSC_CTL_READ] && !cmd_prog;
	assign cmd_ok   = prog_allowed(sec_cfg_q, aport_q, i_wdata[`OSC_CTL_SECTGT]);

	// debug path gating
	assign dbg_otp    = i_dbg_req.valid && i_dbg_req.otp;
	assign dbg_denied = sec_cfg_q[`OSC_SEC_DBG_OFF]
	                 || sec_cfg_q[`OSC_SEC_DBG_OTP]
	                 || !booted;
	assign dbg_ok     = prog_allowed(sec_cfg_q, i_dbg_req.addr, 1'b0);
	assign dbg_prog   = dbg_otp && i_dbg_req.write && !dbg_denied && dbg_ok
	                 && !seq_busy && !cmd_prog;
	assign dbg_read   = dbg_otp && !i_dbg_req.write && !dbg_denied && !cmd_read;

	// processor wins the pulse when both ask in one cycle
	assign seq_start = !seq_busy && ((cmd_prog && cmd_ok) || dbg_prog);

	// address and data ports, writable at any time, even while a pulse runs
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			aport_q <= 16'h0000;
			dport_q <= 32'h00000000;
		end else if (i_clk_en && i_wr) begin
			if (i_addr == `OSC_ADDR_APORT)
				aport_q <= i_wdata[15:0];
			if (i_addr == `OSC_ADDR_DPORT)
				dport_q <= i_wdata;
		end
	end

	// latch target of a started pulse
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			prog_sec_q <= 1'b0;
			prog_dbg_q <= 1'b0;
			dbg_addr_q <= 16'h0000;
			dbg_data_q <= 32'h00000000;
		end else if (i_clk_en && seq_start) begin
			prog_dbg_q <= !(cmd_prog && cmd_ok);
			prog_sec_q <= cmd_prog && cmd_ok && i_wdata[`OSC_CTL_SECTGT];
			dbg_addr_q <= i_dbg_req.addr;
			dbg_data_q <= i_dbg_req.wdata;
		end
	end

	// =============================================================
	// array access mux; the loader owns it until booted
	always_comb begin
		arr_rd_en   = 1'b0;
		arr_rd_addr = copy_idx_q;
		if (ld_q == OSC_LD_READ) begin
			arr_rd_en = 1'b1;
		end else if (cmd_read) begin
			arr_rd_en   = 1'b1;
			arr_rd_addr = aport_q[`OSC_WADDR_W-1:0];
		end else if (dbg_read) begin
			arr_rd_en   = 1'b1;
			arr_rd_addr = i_dbg_req.addr[`OSC_WADDR_W-1:0];
		end
	end

	// commit: ports are read at the end of the pulse, as the host holds them
	assign arr_wr_en   = seq_fire && !prog_sec_q;
	assign arr_wr_addr = prog_dbg_q ? dbg_addr_q[`OSC_WADDR_W-1:0]
	                                : aport_q[`OSC_WADDR_W-1:0];
	assign arr_wr_data = prog_dbg_q ? dbg_data_q : dport_q;

	// security cell: nonvolatile, only the blank input clears it
	always_ff @(posedge i_clock) begin
		if (i_clk_en) begin
			if (i_blank)
				sec_cell_q <= 32'h00000000;
			else if (seq_fire && prog_sec_q)
				sec_cell_q <= sec_cell_q | dport_q;
		end
	end

	// =============================================================
	// status flags; a new event wins over the clearing write
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			done_q    <= 1'b0;
			lockerr_q <= 1'b0;
		end else if (i_clk_en) begin
			if (seq_fire)
				done_q <= 1'b1;
			else if (cmd_wr)
				done_q <= 1'b0;
			if (cmd_prog && !cmd_ok)
				lockerr_q <= 1'b1;
			else if (cmd_wr)
				lockerr_q <= 1'b0;
		end
	end

	// bus OTP read lands in the data-port read value
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			rd_pend_q <= 1'b0;
			otp_rd_q  <= 32'h00000000;
		end else if (i_clk_en) begin
			rd_pend_q <= cmd_read;
			if (rd_pend_q)
				otp_rd_q <= arr_rdata;
		end
	end

	// =============================================================
	// register read: one cycle later, unmapped reads as zero
	always_ff @(posedge i_clock) begin
		if (i_srst)
			rdata_q <= 32'h00000000;
		else if (i_clk_en) begin
			if (i_rd) begin
				case (i_addr)
					`OSC_ADDR_APORT:    rdata_q <= {16'h0000, aport_q};
					`OSC_ADDR_DPORT:    rdata_q <= otp_rd_q;
					`OSC_ADDR_CPORT:    rdata_q <= {28'h0000000, booted, lockerr_q,
					                               done_q, seq_busy};
					`OSC_ADDR_SECURITY: rdata_q <= sec_cfg_q;
					default:            rdata_q <= 32'h00000000;
				endcase
			end else begin
				rdata_q <= 32'h00000000;
			end
		end
	end

	assign o_rdata = rdata_q;

	// =============================================================
	// debug answer: one cycle after each request; idle fields never refuse
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			dbg_rsp_q <= 1'b0;
			dbg_ref_q <= 1'b0;
			dbg_rd_q  <= 1'b0;
		end else if (i_clk_en) begin
			dbg_rsp_q <= i_dbg_req.valid;
			dbg_rd_q  <= dbg_read;
			if (!i_dbg_req.valid)
				dbg_ref_q <= 1'b0;
			else if (i_dbg_req.otp)
				dbg_ref_q <= !(dbg_prog || dbg_read);
			else
				dbg_ref_q <= sec_cfg_q[`OSC_SEC_DBG_OFF] || !booted;
		end
	end

	assign o_dbg_rsp.valid   = dbg_rsp_q;
	assign o_dbg_rsp.refused = dbg_ref_q;
	assign o_dbg_rsp.rdata   = dbg_rd_q ? arr_rdata : 32'h00000000; // only served reads

	// =============================================================
	// security outputs from the captured word; boot flag and copy stream from the loader
	assign o_dbg_tile_en = booted && !sec_cfg_q[`OSC_SEC_DBG_OFF];
	assign o_link_grant  = i_link_req && !sec_cfg_q[`OSC_SEC_LINK_OFF];
	assign o_boot_go     = booted;
	assign o_boot_otp    = sec_cfg_q[`OSC_SEC_SBOOT];
	assign o_redund_en   = sec_cfg_q[`OSC_SEC_REDUND];
	assign o_sram_wr     = sram_q;

	// usercode: user field on top, revision low; zero field when blank
	assign o_usercode = {sec_cfg_q[`OSC_SEC_UID_MSB:`OSC_SEC_UID_LSB],
	                     14'h0000, `OSC_SILICON_REV};
endmodule

/* File: inc/osc_regs.svh */
// Purpose : constants for the tile OTP security controller
// Assumes : included by bare name after the package
// Notes   : addresses are the I/O resource identifiers on the register port
//
// Functional notes
// - 8 KB: four sectors of 512 32-bit rows
// - security word loaded from OTP at power-up
// - remaining OTP copied to SRAM before code
// - bit 0 refuses all debug access
// - bit 1 denies switch access from tiles
// - bit 5 boots from OTP address zero
// - bit 7 enables redundant OTP rows
// - bits 8-11 lock sectors 0-3 in order
// - bit 12 rejects every programming update
// - bit 13 blocks debug OTP reads and writes
// - bits 21:15 software-readable general field
// - bits 31:22 user identification extension
// - address port 16-bit, id 0x100200
// - data port 32-bit, id 0x200100
// - control port 16-bit, id 0x100300
// - debug usercode reports bits 31:22
`ifndef OSC_REGS_SVH
`define OSC_REGS_SVH

// =============================================================
// geometry
`define OSC_SECTORS        4
`define OSC_ROWS           512
`define OSC_WORDS          2048
`define OSC_WADDR_W        11
`define OSC_SECTOR_LSB     9

// =============================================================
// register port addresses
`define OSC_ADDR_W         24
`define OSC_ADDR_APORT     24'h100200
`define OSC_ADDR_DPORT     24'h200100
`define OSC_ADDR_CPORT     24'h100300
`define OSC_ADDR_SECURITY  24'h100400

// =============================================================
// security_config fields
`define OSC_SEC_DBG_OFF    0
`define OSC_SEC_LINK_OFF   1
`define OSC_SEC_SBOOT      5
`define OSC_SEC_REDUND     7
`define OSC_SEC_LOCK0      8
`define OSC_SEC_MLOCK      12
`define OSC_SEC_DBG_OTP    13
`define OSC_SEC_GP_MSB     21
`define OSC_SEC_GP_LSB     15
`define OSC_SEC_UID_MSB    31
`define OSC_SEC_UID_LSB    22
`define OSC_SEC_RESET      32'h00000000

// =============================================================
// control port bits, status bits on control read
`define OSC_CTL_PROG       0
`define OSC_CTL_SECTGT     1
`define OSC_CTL_READ       2
`define OSC_STS_BUSY       0
`define OSC_STS_DONE       1
`define OSC_STS_LOCKERR    2
`define OSC_STS_BOOTED     3

// =============================================================
// timing
`define OSC_CLK_PERIOD_NS  4
`define OSC_PROG_TIME_NS   10000
`define OSC_PROG_CYCLES    ((`OSC_PROG_TIME_NS + `OSC_CLK_PERIOD_NS - 1) / `OSC_CLK_PERIOD_NS)
`define OSC_SILICON_REV    8'h00

`endif

/* File: inc/osc_pkg.sv */
// Purpose : shared types of the OTP security controller
// Assumes : nothing
// Notes   : widths follow the constants header
package osc_pkg;

	// =============================================================
	// debug port request and answer
	typedef struct packed {
		logic        valid;  // one-cycle request
		logic        write;  // program when set
		logic        otp;    // target OTP, else tile state
		logic [15:0] addr;   // OTP word address
		logic [31:0] wdata;  // program data
	} osc_dbg_req_t;

	typedef struct packed {
		logic        valid;   // answer, one cycle
		logic        refused; // access denied
		logic [31:0] rdata;   // OTP read data
	} osc_dbg_rsp_t;

	// =============================================================
	// boot copy into SRAM
	typedef struct packed {
		logic        valid; // one word
		logic [10:0] addr;  // word index
		logic [31:0] data;  // word
	} osc_sram_wr_t;

	typedef enum logic [1:0] {
		OSC_LD_FETCH,
		OSC_LD_READ,
		OSC_LD_WRITE,
		OSC_LD_DONE
	} osc_ld_state_t;

endpackage

/* File: hdl/osc_otp_array.sv */
// Purpose : one-time programmable word store in flip-flops
// Assumes : one read and one write per cycle, chosen by the controller
// Notes   : programming can only set bits; i_blank models a fresh part
`include "osc_regs.svh"
module osc_otp_array
	import osc_pkg::*;
(
	input  wire logic                    i_clock,   // tile clock
	input  wire logic                    i_clk_en,  // freeze when low
	input  wire logic                    i_blank,   // clear to unprogrammed
	input  wire logic                    i_wr_en,   // program strobe
	input  wire logic [`OSC_WADDR_W-1:0] i_wr_addr, // program address
	input  wire logic [31:0]             i_wr_data, // bits to set
	input  wire logic                    i_rd_en,   // read strobe
	input  wire logic [`OSC_WADDR_W-1:0] i_rd_addr, // read address
	output logic      [31:0]             o_rd_data  // read data next cycle
);
	logic [31:0] mem_q [`OSC_WORDS];

	// =============================================================
	// cells: fuses only blow, so a write ORs in
	genvar g;
	generate
		for (g = 0; g < `OSC_WORDS; g++) begin : g_word
			always_ff @(posedge i_clock) begin
				if (i_clk_en) begin
					if (i_blank)
						mem_q[g] <= 32'h00000000;
					else if (i_wr_en && i_wr_addr == `OSC_WADDR_W'(g))
						mem_q[g] <= mem_q[g] | i_wr_data;
				end
			end
		end
	endgenerate

	// registered read port
	always_ff @(posedge i_clock) begin
		if (i_clk_en && i_rd_en)
			o_rd_data <= mem_q[i_rd_addr];
	end
endmodule

/* File: hdl/osc_prog_seq.sv */
// Purpose : times one OTP programming pulse
// Assumes : start only while idle
// Notes   : fire pulses in the last cycle of the pulse time
`include "osc_regs.svh"
module osc_prog_seq
	import osc_pkg::*;
#(
	parameter int unsigned PROG_CYCLES = `OSC_PROG_CYCLES // pulse length
)(
	input  wire logic i_clock,  // tile clock
	input  wire logic i_clk_en, // freeze when low
	input  wire logic i_srst,   // sync reset
	input  wire logic i_start,  // begin pulse
	output logic      o_busy,   // pulse in progress
	output logic      o_fire    // commit write, one cycle
);
	logic [15:0] cnt_q;

	// =============================================================
	// down counter; busy is the counter being nonzero
	always_ff @(posedge i_clock) begin
		if (i_srst)
			cnt_q <= 16'h0000;
		else if (i_clk_en) begin
			if (i_start && cnt_q == 16'h0000)
				cnt_q <= 16'(PROG_CYCLES);
			else if (cnt_q != 16'h0000)
				cnt_q <= cnt_q - 16'h0001;
		end
	end

	assign o_busy = (cnt_q != 16'h0000);
	assign o_fire = (cnt_q == 16'h0001);
endmodule

/* File: verif/osc_top_props.sv */
// Purpose : port assertions of the OTP security controller
// Assumes : i_clk_en held high by the bench
// Notes   : security shadow is internal, so checks go through outputs
`include "osc_regs.svh"
module osc_top_props
	import osc_pkg::*;
(
	input  wire logic         i_clock,       // tile clock
	input  wire logic         i_srst,        // sync reset
	input  wire logic         i_rd,          // read strobe
	input  wire logic [31:0]  o_rdata,       // read data
	input  wire osc_dbg_req_t i_dbg_req,     // debug request
	input  wire osc_dbg_rsp_t o_dbg_rsp,     // debug answer
	input  wire logic [31:0]  o_usercode,    // usercode
	input  wire logic         i_link_req,    // switch request
	input  wire logic         o_link_grant,  // switch grant
	input  wire logic         o_dbg_tile_en, // debug tile reach
	input  wire osc_sram_wr_t o_sram_wr,     // boot copy
	input  wire logic         o_boot_go,     // boot done
	input  wire logic         o_boot_otp,    // boot from OTP
	input  wire logic         o_redund_en    // redundant rows
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_srst);
	logic        seen_q;
	logic [10:0] last_q;
	// =============================================================
	// copy order tracking, cleared by reset so each boot starts at 0
	always_ff @(posedge i_clock) begin
		if (i_srst) seen_q <= 1'b0;
		else if (o_sram_wr.valid) seen_q <= 1'b1;
	end
	always_ff @(posedge i_clock) begin
		if (o_sram_wr.valid) last_q <= o_sram_wr.addr;
	end
	sequence s_req;
		i_dbg_req.valid;
	endsequence
	sequence s_ans;
		o_dbg_rsp.valid;
	endsequence
	// =============================================================
	// assertions
	AST_DBG_ANSWER: assert property (s_req |=> s_ans)
		else $error("debug request not answered next cycle");
	AST_NO_SPURIOUS: assert property (s_ans |-> $past(i_dbg_req.valid))
		else $error("debug answer without request");
	AST_PREBOOT: assert property (s_req and (i_dbg_req.otp && !o_boot_go) |=> o_dbg_rsp.refused)
		else $error("debug OTP access served before boot");
	AST_REFUSE_NODATA: assert property (o_dbg_rsp.refused |-> s_ans and o_dbg_rsp.rdata == 32'h0)
		else $error("refused answer carries data");
	AST_RDATA_ONE: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("read data outside its cycle");
	AST_LINK_GATE: assert property (o_link_grant |-> i_link_req)
		else $error("grant without request");
	AST_TILE_BOOT: assert property (o_dbg_tile_en |-> o_boot_go)
		else $error("debug reaches tile before boot");
	AST_USER_LOW: assert property (o_usercode[21:0] == 22'h0)
		else $error("usercode low field not zero");
	AST_CFG_HOLD: assert property (o_boot_go |-> $stable({o_usercode, o_boot_otp, o_redund_en}))
		else $error("security outputs moved after boot");
	AST_SRAM_GAP: assert property (o_sram_wr.valid |=> !o_sram_wr.valid)
		else $error("copy words back to back");
	AST_SRAM_SEQ: assert property (o_sram_wr.valid |-> o_sram_wr.addr == (seen_q ? last_q + 11'h1 : 11'h0))
		else $error("copy address out of order");
	AST_COPY_FIRST: assert property (o_sram_wr.valid |-> !o_boot_go)
		else $error("processor released during copy");
	AST_BOOT_HOLD: assert property (o_boot_go |=> o_boot_go)
		else $error("boot flag dropped");
endmodule

bind osc_top osc_top_props osc_top_props_i (.i_clock(i_clock), .i_srst(i_srst), .i_rd(i_rd),
	.o_rdata(o_rdata), .i_dbg_req(i_dbg_req), .o_dbg_rsp(o_dbg_rsp), .o_usercode(o_usercode),
	.i_link_req(i_link_req), .o_link_grant(o_link_grant), .o_dbg_tile_en(o_dbg_tile_en),
	.o_sram_wr(o_sram_wr), .o_boot_go(o_boot_go), .o_boot_otp(o_boot_otp),
	.o_redund_en(o_redund_en));

/* File: verif/osc_dbg_model.sv */
// Purpose : debug test port probe driving the controller
// Assumes : one request in flight at a time
// Notes   : released fields show inverted values, not the old ones
module osc_dbg_model
	import osc_pkg::*;
(
	input  wire logic         i_clock, // tile clock
	output osc_dbg_req_t      o_req,   // debug request
	input  wire osc_dbg_rsp_t i_rsp    // debug answer
);
	timeunit 1ns;
	timeprecision 100ps;
	initial o_req = '0;
	// =============================================================
	// one access: pulse request, take answer in the following cycle
	task automatic access(input logic w, input logic otp, input logic [15:0] a,
		output osc_dbg_rsp_t r);
		@(posedge i_clock);
		o_req <= '{1'b1, w, otp, a, 32'hA5A5_0F0F};
		@(posedge i_clock);
		o_req <= '{1'b0, ~w, ~otp, ~a, 32'h5A5A_F0F0}; // no stale fields
		#1 r = i_rsp;
	endtask
endmodule

/* File: verif/osc_top_tb_top.sv */
// Purpose : self-checking bench of the OTP security controller
// Assumes : short programming pulse, blank part at start
// Notes   : expected OTP image is kept in exp_mem across boots
`include "osc_regs.svh"
module osc_top_tb_top
	import osc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int unsigned PC    = 4;
	localparam logic [31:0] SEC_B = 32'hA96A_A2A2; // bits 1,5,7,9,13, gp 55, ident 2A5
	localparam logic [31:0] SEC_C = 32'hA96A_B2A3; // adds bits 0 and 12
	logic         clk = 1'b0;
	logic         srst = 1'b1;
	logic         blank = 1'b1;
	logic         wr = 1'b0;
	logic         rd = 1'b0;
	logic         link = 1'b0;
	logic [23:0]  addr = 24'h0;
	logic [31:0]  wdata = 32'h0;
	logic [31:0]  rdata, ucode;
	logic         grant, tile_en, boot_go, boot_otp, redund;
	osc_dbg_req_t dreq;
	osc_dbg_rsp_t drsp;
	osc_sram_wr_t sw;
	logic [31:0]  exp_mem [0:2047];
	int           miscompares = 0;
	int           tests_run = 0;
	int           words = 0;

	initial forever #2 clk = ~clk;

	osc_top #(.PROG_CYCLES(PC)) osc_top_i (.i_clock(clk), .i_srst(srst), .i_clk_en(1'b1),
		.i_blank(blank), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdata), .i_dbg_req(dreq), .o_dbg_rsp(drsp), .o_usercode(ucode),
		.i_link_req(link), .o_link_grant(grant), .o_dbg_tile_en(tile_en), .o_sram_wr(sw),
		.o_boot_go(boot_go), .o_boot_otp(boot_otp), .o_redund_en(redund));
	osc_dbg_model osc_dbg_model_i (.i_clock(clk), .o_req(dreq), .i_rsp(drsp));

	// =============================================================
	// shared helpers
	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic hang(input string m);
		miscompares++;
		$display("CHECK FAILED %0t wait ran out: %s", $time, m);
		stop_test();
	endtask
	task automatic wr_reg(input logic [23:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [23:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// address then data then command, both held until busy clears
	task automatic prog(input logic [15:0] a, input logic [31:0] d, input logic [1:0] c,
		output logic [31:0] s);
		wr_reg(`OSC_ADDR_APORT, {16'h0, a});
		wr_reg(`OSC_ADDR_DPORT, d);
		wr_reg(`OSC_ADDR_CPORT, {30'h0, c});
		for (int i = 0; i < 40; i++) begin
			rd_reg(`OSC_ADDR_CPORT, s);
			if (s[`OSC_STS_BUSY] === 1'b0) return;
		end
		hang("busy");
	endtask
	task automatic otp_rd(input logic [15:0] a, input string m);
		logic [31:0] d;
		wr_reg(`OSC_ADDR_APORT, {16'h0, a});
		wr_reg(`OSC_ADDR_CPORT, 32'h1 << `OSC_CTL_READ);
		rd_reg(`OSC_ADDR_DPORT, d);
		chk(d, exp_mem[a[10:0]], m);
	endtask
	task automatic dbg(input logic otp, input logic [15:0] a, input logic [32:0] e, input string m);
		osc_dbg_rsp_t r;
		osc_dbg_model_i.access(1'b0, otp, a, r);
		chk({r.valid, r.refused, r.rdata}, {1'b1, e}, m);
	endtask
	task automatic link_chk(input logic e);
		@(posedge clk);
		link <= 1'b1;
		@(posedge clk);
		chk(grant, e, "link grant");
		link <= 1'b0;
	endtask
	// copy stream monitor: every word in order with the expected image
	always @(posedge clk) begin
		if (!srst && sw.valid) begin
			chk(sw.addr, words, "copy order");
			chk(sw.data, exp_mem[sw.addr], "copy data");
			words++;
		end
	end
	task automatic boot(input logic b);
		words = 0;
		@(posedge clk);
		srst <= 1'b1;
		blank <= b;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		blank <= 1'b0;
		repeat (20) @(posedge clk);
		dbg(1'b1, 16'h0, {1'b1, 32'h0}, "debug before boot");
		for (int i = 0; i < 6000 && boot_go !== 1'b1; i++) @(posedge clk);
		if (boot_go !== 1'b1) hang("boot");
		repeat (2) @(posedge clk);
		chk(words, 2048, "copied words");
	endtask

	// =============================================================
	// scenarios
	task automatic t_blank();
		logic [31:0] d;
		osc_dbg_rsp_t r;
		chk({ucode, boot_otp, redund, tile_en}, 35'h1, "blank outputs");
		rd_reg(`OSC_ADDR_SECURITY, d);
		chk(d, `OSC_SEC_RESET, "security blank");
		rd_reg(24'h000010, d);
		chk(d, 32'h0, "unmapped read");
		prog(16'h0205, 32'h0000_5A00, 2'b01, d);
		prog(16'h0205, 32'h0300_0001, 2'b01, d);
		chk(d[3:0], 4'hA, "status done");
		exp_mem[11'h205] = 32'h0300_5A01;
		otp_rd(16'h0205, "read back ored");
		dbg(1'b1, 16'h0205, {1'b0, exp_mem[11'h205]}, "debug otp read");
		dbg(1'b0, 16'h0, 33'h0, "debug tile");
		// debug write of the model's fixed word, then wait out the pulse
		osc_dbg_model_i.access(1'b1, 1'b1, 16'h0103, r);
		chk({r.valid, r.refused, r.rdata}, {2'b10, 32'h0}, "debug write");
		repeat (8) @(posedge clk);
		exp_mem[11'h103] = 32'hA5A5_0F0F;
		otp_rd(16'h0103, "debug write landed");
		link_chk(1'b1);
		prog(16'h0000, SEC_B, 2'b11, d);
	endtask
	task automatic t_sector_lock();
		logic [31:0] d;
		boot(1'b0);
		chk({ucode[31:22], boot_otp, redund, tile_en}, {SEC_B[31:22], 3'b111}, "sec out");
		rd_reg(`OSC_ADDR_SECURITY, d);
		chk(d, SEC_B, "security word");
		link_chk(1'b0);
		dbg(1'b1, 16'h0205, {1'b1, 32'h0}, "debug otp blocked");
		dbg(1'b0, 16'h0, 33'h0, "debug tile open");
		prog(16'h0205, 32'hFFFF_FFFF, 2'b01, d);
		chk(d[`OSC_STS_LOCKERR], 1'b1, "sector 1 locked");
		otp_rd(16'h0205, "locked word kept");
		prog(16'h0003, 32'h0000_00F0, 2'b01, d);
		exp_mem[11'h003] = 32'h0000_00F0;
		otp_rd(16'h0003, "sector 0 open");
		prog(16'h0000, SEC_C, 2'b11, d);
	endtask
	task automatic t_master_lock();
		logic [31:0] d;
		boot(1'b0);
		rd_reg(`OSC_ADDR_SECURITY, d);
		chk({d, tile_en}, {SEC_C, 1'b0}, "master word");
		dbg(1'b0, 16'h0, {1'b1, 32'h0}, "debug tile blocked");
		prog(16'h0000, 32'h0000_0010, 2'b11, d);
		chk(d[`OSC_STS_LOCKERR], 1'b1, "security locked");
		prog(16'h0400, 32'h0000_0001, 2'b01, d);
		chk(d[`OSC_STS_LOCKERR], 1'b1, "sector 2 locked");
		otp_rd(16'h0400, "master kept");
	endtask

	initial begin
		foreach (exp_mem[i]) exp_mem[i] = 32'h0;
		boot(1'b1);
		t_blank();
		t_sector_lock();
		t_master_lock();
		stop_test();
	end
endmodule
